// ===== hdl/timer16_waveform_mode_control.sv
// waveform-mode decode, counter and compare-output control
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module timer16_waveform_mode_control (
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire logic       tick_enable_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       dir_a_in,
   input  wire logic       dir_b_in,
   input  wire logic       port_a_in,
   input  wire logic       port_b_in,
   input  wire logic       capture_input_pin_in,
   output logic            pin_a_out,
   output logic            pin_a_oe_out,
   output logic            pin_b_out,
   output logic            pin_b_oe_out,
   output logic            compare_out_a_out,
   output logic            compare_out_b_out,
   output logic            capture_enable_out,
   output logic            irq_out
);
   typedef enum logic [1:0] {
      CLS_NORMAL = 2'b00,
      CLS_CTC    = 2'b01,
      CLS_FAST   = 2'b10,
      CLS_DUAL   = 2'b11
   } mode_class_t;

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [15:0] count;
      logic        down;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] buf_a;
      logic [15:0] buf_b;
      logic [15:0] cap;
      logic [7:0]  temp;
      logic [7:0]  status;
      logic [7:0]  mask;
      logic        oc_a;
      logic        oc_b;
      logic [7:0]  rdata;
      logic        cap_q;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [timer16_pkg::SYNC_STAGES-1:0] rst_sync_r;
   logic rst_n;

   // ==========================================================
   // reset release
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_r <= '0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[timer16_pkg::SYNC_STAGES-1];

   // ==========================================================
   // mode decode
   logic [3:0]  wmode;
   mode_class_t cls;
   logic [15:0] top;
   logic        top_cap;
   logic        top_cmpa;
   logic        reload_top;
   logic        reload_bot;
   logic        pfc;
   logic [1:0]  om_a;
   logic [1:0]  om_b;

   always_comb begin
      wmode = {st_r.ctrl_b[4:3], st_r.ctrl_a[1:0]};
      om_a  = st_r.ctrl_a[7:6];
      om_b  = st_r.ctrl_a[5:4];
      top_cap  = 1'b0;
      top_cmpa = 1'b0;
      reload_top = 1'b0;
      reload_bot = 1'b0;
      pfc = 1'b0;
      top = timer16_pkg::TOP_MAX;
      case (wmode)
         4'h0: begin
            cls = CLS_NORMAL;
         end
         4'h4: begin
            cls = CLS_CTC;
            top_cmpa = 1'b1;
         end
         4'hc: begin
            cls = CLS_CTC;
            top_cap = 1'b1;
         end
         4'h1, 4'h2, 4'h3: begin
            cls = CLS_DUAL;
            reload_top = 1'b1;
         end
         4'ha, 4'hb: begin
            cls = CLS_DUAL;
            reload_top = 1'b1;
            top_cap  = ~wmode[0];
            top_cmpa = wmode[0];
         end
         4'h5, 4'h6, 4'h7: begin
            cls = CLS_FAST;
            reload_bot = 1'b1;
         end
         4'he, 4'hf: begin
            cls = CLS_FAST;
            reload_bot = 1'b1;
            top_cap  = ~wmode[0];
            top_cmpa = wmode[0];
         end
         4'h8, 4'h9: begin
            cls = CLS_DUAL;
            reload_bot = 1'b1;
            pfc = 1'b1;
            top_cap  = ~wmode[0];
            top_cmpa = wmode[0];
         end
         default: begin
            cls = CLS_NORMAL; // reserved 13 behaves as normal
         end
      endcase
      case (wmode[1:0])
         2'b01:   top = timer16_pkg::TOP_8BIT;
         2'b10:   top = timer16_pkg::TOP_9BIT;
         2'b11:   top = timer16_pkg::TOP_10BIT;
         default: top = timer16_pkg::TOP_MAX;
      endcase
      if (wmode[3] || wmode == 4'h4) begin
         top = timer16_pkg::TOP_MAX;
      end
      if (top_cap) begin
         top = st_r.cap;
      end
      if (top_cmpa) begin
         top = st_r.cmp_a;
      end
   end

   // ==========================================================
   // counter, compare actions, registers
   logic at_top;
   logic at_bot;
   logic at_max;
   logic match_a;
   logic match_b;
   logic cap_edge;
   logic [7:0] ev;
   logic [7:0] wmask;

   function automatic logic oc_next(input logic cur, input logic [1:0] om,
                                    input logic chan_a, input logic hit,
                                    input logic cmp_is_top, input logic bot,
                                    input mode_class_t c, input logic dn,
                                    input logic [3:0] m);
      logic r;
      r = cur;
      case (c)
         CLS_NORMAL, CLS_CTC: begin
            if (hit) begin
               case (om)
                  2'b01:   r = ~cur;
                  2'b10:   r = 1'b0;
                  2'b11:   r = 1'b1;
                  default: r = cur;
               endcase
            end
         end
         CLS_FAST: begin
            if (om[1]) begin
               if (hit && !cmp_is_top) begin
                  r = om[0];
               end else if (bot) begin
                  r = ~om[0];
               end
            end else if (om == 2'b01 && chan_a && m[3:1] == 3'b111 && hit) begin
               r = ~cur;
            end
         end
         default: begin
            if (om[1] && hit) begin
               r = om[0] ^ dn;
            end else if (om == 2'b01 && chan_a && m[3] && m[0] && !m[2]
                         && hit) begin
               r = ~cur;
            end
         end
      endcase
      return r;
   endfunction

   always_comb begin
      st_nxt = st_r;
      ev = 8'h00;
      at_top = (st_r.count == top);
      at_bot = (st_r.count == timer16_pkg::BOTTOM);
      at_max = (st_r.count == timer16_pkg::TOP_MAX);
      match_a = (st_r.count == st_r.cmp_a);
      match_b = (st_r.count == st_r.cmp_b);
      st_nxt.cap_q = capture_input_pin_in;
      cap_edge = capture_input_pin_in & ~st_r.cap_q & ~top_cap;
      if (tick_enable_in) begin
         case (cls)
            CLS_DUAL: begin
               if (at_top && !st_r.down) begin
                  st_nxt.down = 1'b1;
                  st_nxt.count = st_r.count - 16'h0001;
               end else if (at_bot && st_r.down) begin
                  st_nxt.down = 1'b0;
                  st_nxt.count = st_r.count + 16'h0001;
               end else if (st_r.down) begin
                  st_nxt.count = st_r.count - 16'h0001;
               end else begin
                  st_nxt.count = st_r.count + 16'h0001;
               end
               if (at_bot) begin
                  ev[timer16_pkg::STAT_OVF] = 1'b1;
               end
            end
            CLS_NORMAL: begin
               st_nxt.down = 1'b0;
               st_nxt.count = st_r.count + 16'h0001;
            end
            default: begin
               st_nxt.down = 1'b0;
               st_nxt.count = at_top ? timer16_pkg::BOTTOM
                                     : st_r.count + 16'h0001;
               if (cls == CLS_FAST && at_top) begin
                  ev[timer16_pkg::STAT_OVF] = 1'b1;
               end
            end
         endcase
         if (cls != CLS_FAST && cls != CLS_DUAL && at_max) begin
            ev[timer16_pkg::STAT_OVF] = 1'b1;
         end
         if (match_a) ev[timer16_pkg::STAT_CMPA] = 1'b1;
         if (match_b) ev[timer16_pkg::STAT_CMPB] = 1'b1;
         if (pfc && at_top) begin
            if (top_cap) ev[timer16_pkg::STAT_CAP] = 1'b1;
            if (top_cmpa) ev[timer16_pkg::STAT_CMPA] = 1'b1;
         end
         st_nxt.oc_a = oc_next(st_r.oc_a, om_a, 1'b1, match_a,
                               st_r.cmp_a == top, at_bot, cls,
                               st_r.down, wmode);
         st_nxt.oc_b = oc_next(st_r.oc_b, om_b, 1'b0, match_b,
                               st_r.cmp_b == top, at_bot, cls,
                               st_r.down, wmode);
         if ((reload_top && at_top) || (reload_bot && at_bot)) begin
            st_nxt.cmp_a = st_r.buf_a;
            st_nxt.cmp_b = st_r.buf_b;
         end
      end
      if (cap_edge) begin
         st_nxt.cap = st_r.count;
         ev[timer16_pkg::STAT_CAP] = 1'b1;
      end
      // register writes
      wmask = 8'h00;
      if (wr_in) begin
         case (addr_in)
            timer16_pkg::ADDR_CTRL_A:
               st_nxt.ctrl_a = wdata_in & timer16_pkg::CTRL_A_USED;
            timer16_pkg::ADDR_CTRL_B:
               st_nxt.ctrl_b = wdata_in & timer16_pkg::CTRL_B_USED;
            timer16_pkg::ADDR_CNT_H, timer16_pkg::ADDR_CAP_H,
            timer16_pkg::ADDR_CMPA_H, timer16_pkg::ADDR_CMPB_H:
               st_nxt.temp = wdata_in;
            timer16_pkg::ADDR_CNT_L:
               st_nxt.count = {st_r.temp, wdata_in};
            timer16_pkg::ADDR_CAP_L:
               st_nxt.cap = {st_r.temp, wdata_in};
            timer16_pkg::ADDR_CMPA_L: begin
               st_nxt.buf_a = {st_r.temp, wdata_in};
               if (!reload_top && !reload_bot) begin
                  st_nxt.cmp_a = {st_r.temp, wdata_in};
               end
            end
            timer16_pkg::ADDR_CMPB_L: begin
               st_nxt.buf_b = {st_r.temp, wdata_in};
               if (!reload_top && !reload_bot) begin
                  st_nxt.cmp_b = {st_r.temp, wdata_in};
               end
            end
            timer16_pkg::ADDR_STATUS:
               wmask = wdata_in;
            timer16_pkg::ADDR_MASK:
               st_nxt.mask = wdata_in & timer16_pkg::STAT_USED;
            default: ;
         endcase
      end
      // set wins over write-one-to-clear
      st_nxt.status = ((st_r.status & ~wmask) | ev) & timer16_pkg::STAT_USED;
      st_nxt.rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            timer16_pkg::ADDR_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
            timer16_pkg::ADDR_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
            timer16_pkg::ADDR_CNT_L: begin
               st_nxt.rdata = st_r.count[7:0];
               st_nxt.temp = st_r.count[15:8];
            end
            timer16_pkg::ADDR_CAP_L: begin
               st_nxt.rdata = st_r.cap[7:0];
               st_nxt.temp = st_r.cap[15:8];
            end
            timer16_pkg::ADDR_CMPA_L: st_nxt.rdata = st_r.cmp_a[7:0];
            timer16_pkg::ADDR_CMPA_H: st_nxt.rdata = st_r.cmp_a[15:8];
            timer16_pkg::ADDR_CMPB_L: st_nxt.rdata = st_r.cmp_b[7:0];
            timer16_pkg::ADDR_CMPB_H: st_nxt.rdata = st_r.cmp_b[15:8];
            timer16_pkg::ADDR_CNT_H,
            timer16_pkg::ADDR_CAP_H:  st_nxt.rdata = st_r.temp;
            timer16_pkg::ADDR_STATUS: st_nxt.rdata = st_r.status;
            timer16_pkg::ADDR_MASK:   st_nxt.rdata = st_r.mask;
            default:                  st_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   logic own_a;
   logic own_b;
   always_comb begin
      own_a = om_a[1] | (om_a[0] & (~cls[1] | wmode[3:1] == 3'b111
         | wmode == 4'h9 | wmode == 4'hb));
      own_b = om_b[1] | (om_b[0] & ~cls[1]);
      pin_a_out = own_a ? st_r.oc_a : port_a_in;
      pin_b_out = own_b ? st_r.oc_b : port_b_in;
   end
   assign pin_a_oe_out       = dir_a_in;
   assign pin_b_oe_out       = dir_b_in;
   assign compare_out_a_out  = st_r.oc_a;
   assign compare_out_b_out  = st_r.oc_b;
   assign capture_enable_out = ~top_cap;
   assign rdata_out          = st_r.rdata;
   assign irq_out            = |(st_r.status & st_r.mask);

   // ==========================================================
   // checks
   a_tick_gates_count: assert property (@(posedge mclk_in) disable iff (!rst_n)
      !tick_enable_in && !wr_in |=> $stable(st_r.count))
      else $error("count moved without tick");
   a_mode_from_regs: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wmode == {st_r.ctrl_b[4:3], st_r.ctrl_a[1:0]})
      else $error("mode field mismatch");
   a_pin_owned: assert property (@(posedge mclk_in) disable iff (!rst_n)
      (om_a[1] || (om_a == 2'b01 && (cls == CLS_NORMAL || cls == CLS_CTC)))
      |-> pin_a_out == st_r.oc_a)
      else $error("pin A not owned by compare output");
   a_pin_b_free: assert property (@(posedge mclk_in) disable iff (!rst_n)
      om_b == 2'b01 && (cls == CLS_FAST || cls == CLS_DUAL)
      |-> pin_b_out == port_b_in)
      else $error("pin B not released in pwm mode");
   a_pin_dir: assert property (@(posedge mclk_in) disable iff (!rst_n)
      pin_b_oe_out == dir_b_in)
      else $error("pin B enable not from direction");
   a_ctc_set: assert property (@(posedge mclk_in) disable iff (!rst_n)
      tick_enable_in && cls == CLS_CTC && om_a == 2'b11 && match_a
      |=> st_r.oc_a)
      else $error("set on match failed");
   a_fast_bottom: assert property (@(posedge mclk_in) disable iff (!rst_n)
      tick_enable_in && cls == CLS_FAST && om_b == 2'b10 && at_bot && !match_b
      |=> st_r.oc_b)
      else $error("fast pwm bottom set failed");
   a_fast_top_ovf: assert property (@(posedge mclk_in) disable iff (!rst_n)
      tick_enable_in && cls == CLS_FAST && at_top
      |=> st_r.status[timer16_pkg::STAT_OVF])
      else $error("fast pwm overflow missing at top");
   a_dual_bot_ovf: assert property (@(posedge mclk_in) disable iff (!rst_n)
      tick_enable_in && cls == CLS_DUAL && at_bot
      |=> st_r.status[timer16_pkg::STAT_OVF])
      else $error("dual slope overflow missing at bottom");
   a_cap_off: assert property (@(posedge mclk_in) disable iff (!rst_n)
      top_cap |-> !capture_enable_out)
      else $error("capture not disconnected");
   a_pfc_top_flag: assert property (@(posedge mclk_in) disable iff (!rst_n)
      tick_enable_in && wmode == 4'h9 && at_top
      |=> st_r.status[timer16_pkg::STAT_CMPA])
      else $error("pfc top flag missing");
endmodule

// ===== hdl/timer16_pkg.sv
// constants and register map of the 16-bit waveform timer
package timer16_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_CTRL_A  = 8'h80;
   localparam logic [7:0] ADDR_CTRL_B  = 8'h81;
   localparam logic [7:0] ADDR_CNT_L   = 8'h84;
   localparam logic [7:0] ADDR_CNT_H   = 8'h85;
   localparam logic [7:0] ADDR_CAP_L   = 8'h86;
   localparam logic [7:0] ADDR_CAP_H   = 8'h87;
   localparam logic [7:0] ADDR_CMPA_L  = 8'h88;
   localparam logic [7:0] ADDR_CMPA_H  = 8'h89;
   localparam logic [7:0] ADDR_CMPB_L  = 8'h8a;
   localparam logic [7:0] ADDR_CMPB_H  = 8'h8b;
   localparam logic [7:0] ADDR_STATUS  = 8'h8c;
   localparam logic [7:0] ADDR_MASK    = 8'h8d;
   // ==========================================================
   // field positions and values
   localparam int         STAT_OVF     = 0;
   localparam int         STAT_CMPA    = 1;
   localparam int         STAT_CMPB    = 2;
   localparam int         STAT_CAP     = 5;
   localparam logic [7:0] STAT_USED    = 8'h27;
   localparam logic [7:0] CTRL_A_USED  = 8'hf3;
   localparam logic [7:0] CTRL_B_USED  = 8'h18;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [15:0] RESET_WORD  = 16'h0000;
   localparam logic [15:0] TOP_MAX     = 16'hffff;
   localparam logic [15:0] TOP_8BIT    = 16'h00ff;
   localparam logic [15:0] TOP_9BIT    = 16'h01ff;
   localparam logic [15:0] TOP_10BIT   = 16'h03ff;
   localparam logic [15:0] BOTTOM      = 16'h0000;
   localparam int         SYNC_STAGES  = 2;
endpackage

// ===== sim/pin_model.sv
// port pin model standing on one compare output pin
`timescale 1ns/1ps
module pin_model (
   input  wire logic mclk_in,
   input  wire logic drive_in,
   input  wire logic oe_in,
   output logic      level_out
);
   logic last_r = 1'b0;
   always @(posedge mclk_in) begin
      if (oe_in) begin
         last_r <= drive_in;
      end
   end
   // released pin shows the inverse of what it last carried
   assign level_out = oe_in ? drive_in : ~last_r;
endmodule

// ===== sim/test_timer16_waveform_mode_control.sv
// self-checking bench of the waveform timer block
`timescale 1ns/1ps
module test_timer16_waveform_mode_control;
   logic       mclk = 1'b0, rstn = 1'b0, tick = 1'b0;
   logic       wr = 1'b0, rd = 1'b0, cap_pin = 1'b0;
   logic       dir_a = 1'b1, dir_b = 1'b1;
   logic       port_a = 1'b0, port_b = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       pin_a, pin_a_oe, pin_b, pin_b_oe, lvl_a, lvl_b;
   logic       cmp_a, cmp_b, cap_en, irq;
   int         fail_count = 0;
   int         n_compared = 0;

   always #2 mclk = ~mclk;

   timer16_waveform_mode_control dut_u (
      .mclk_in(mclk), .rstn_in(rstn), .tick_enable_in(tick),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .dir_a_in(dir_a), .dir_b_in(dir_b),
      .port_a_in(port_a), .port_b_in(port_b),
      .capture_input_pin_in(cap_pin), .pin_a_out(pin_a),
      .pin_a_oe_out(pin_a_oe), .pin_b_out(pin_b),
      .pin_b_oe_out(pin_b_oe), .compare_out_a_out(cmp_a),
      .compare_out_b_out(cmp_b), .capture_enable_out(cap_en),
      .irq_out(irq));
   pin_model pin_a_u (.mclk_in(mclk), .drive_in(pin_a),
      .oe_in(pin_a_oe), .level_out(lvl_a));
   pin_model pin_b_u (.mclk_in(mclk), .drive_in(pin_b),
      .oe_in(pin_b_oe), .level_out(lvl_b));

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chkb(input logic seen, input logic exp);
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      wr8(a + 8'h01, v[15:8]);
      wr8(a, v[7:0]);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd8(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask
   task automatic chk_cnt(input logic [15:0] e);
      logic [7:0] lo, hi;
      rd8(timer16_pkg::ADDR_CNT_L, lo);
      rd8(timer16_pkg::ADDR_CNT_H, hi);
      chk({hi, lo}, e);
   endtask
   task automatic clr_stat();
      wr8(timer16_pkg::ADDR_STATUS, 8'hff);
   endtask
   task automatic ticks(input int n);
      @(posedge mclk);
      tick <= 1'b1;
      repeat (n) @(posedge mclk);
      tick <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic mode(input logic [3:0] m, input logic [3:0] f);
      wr8(timer16_pkg::ADDR_CTRL_B, {3'b000, m[3:2], 3'b000});
      wr8(timer16_pkg::ADDR_CTRL_A, {f, 2'b00, m[1:0]});
   endtask
   task automatic setup(input logic [15:0] ca, input logic [15:0] cb);
      mode(4'h0, 4'h0);
      w16(timer16_pkg::ADDR_CMPA_L, ca);
      w16(timer16_pkg::ADDR_CMPB_L, cb);
      w16(timer16_pkg::ADDR_CNT_L, 16'h0000);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      chk_reg(timer16_pkg::ADDR_CTRL_A, 8'h00);
      chk_reg(timer16_pkg::ADDR_CTRL_B, 8'h00);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h00);
      chk_reg(timer16_pkg::ADDR_MASK, 8'h00);
      wr8(8'h82, 8'hff);
      chk_reg(8'h82, 8'h00);
      wr8(timer16_pkg::ADDR_CTRL_A, 8'hff);
      chk_reg(timer16_pkg::ADDR_CTRL_A, timer16_pkg::CTRL_A_USED);
      wr8(timer16_pkg::ADDR_CTRL_B, 8'hff);
      chk_reg(timer16_pkg::ADDR_CTRL_B, timer16_pkg::CTRL_B_USED);
   endtask
   task automatic t_normal();
      setup(16'h0005, 16'h0005);
      mode(4'h0, 4'b0111);
      clr_stat();
      ticks(10);
      chk_cnt(16'h000a);
      chkb(cmp_a, 1'b1);
      chkb(cmp_b, 1'b1);
      chkb(pin_a, cmp_a);
      chkb(lvl_a, 1'b1);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h06);
      repeat (20) @(posedge mclk);
      chk_cnt(16'h000a);
      clr_stat();
      w16(timer16_pkg::ADDR_CNT_L, 16'hfffd);
      ticks(4);
      chk_cnt(16'h0001);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h01);
      wr8(timer16_pkg::ADDR_MASK, 8'h01);
      #1 chkb(irq, 1'b1);
      wr8(timer16_pkg::ADDR_MASK, 8'h02);
      #1 chkb(irq, 1'b0);
      wr8(timer16_pkg::ADDR_MASK, 8'h01);
      wr8(timer16_pkg::ADDR_STATUS, 8'h01);
      #1 chkb(irq, 1'b0);
      @(posedge mclk);
      dir_a <= 1'b0;
      mode(4'h0, 4'b0100);
      port_b <= 1'b1;
      @(posedge mclk);
      #1 chkb(pin_b, 1'b1);
      chkb(pin_a_oe, 1'b0);
      @(posedge mclk);
      dir_a <= 1'b1;
   endtask
   task automatic t_fast();
      setup(16'h0040, 16'h0040);
      mode(4'h5, 4'b1011);
      clr_stat();
      ticks(256);
      chk_cnt(16'h0000);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h07);
      ticks(32);
      chkb(cmp_a, 1'b1);
      chkb(cmp_b, 1'b0);
      w16(timer16_pkg::ADDR_CMPA_L, 16'h0010);
      ticks(64);
      chkb(cmp_a, 1'b0);
      chkb(cmp_b, 1'b1);
      ticks(184);
      chkb(cmp_a, 1'b0);
      mode(4'h5, 4'b0101);
      port_a <= 1'b1;
      @(posedge mclk);
      #1 chkb(pin_a, 1'b1);
      chkb(pin_b, 1'b1);
      mode(4'hf, 4'b0101);
      port_a <= ~cmp_a;
      @(posedge mclk);
      #1 chkb(pin_a, cmp_a);
      chkb(pin_b, 1'b1);
      mode(4'h5, 4'b0010);
      ticks(233);
      chkb(cmp_b, 1'b1);
   endtask
   task automatic t_phase();
      setup(16'h0040, 16'h0040);
      mode(4'h1, 4'b1110);
      ticks(80);
      clr_stat();
      chkb(cmp_a, 1'b1);
      chkb(cmp_b, 1'b0);
      ticks(175);
      chk_cnt(16'h00ff);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h00);
      ticks(208);
      chk_cnt(16'h002f);
      chkb(cmp_a, 1'b0);
      chkb(cmp_b, 1'b1);
      clr_stat();
      ticks(48);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h01);
   endtask
   task automatic t_top();
      setup(16'h0010, 16'h0000);
      mode(4'h4, 4'b1110);
      clr_stat();
      ticks(17);
      chk_cnt(16'h0000);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h06);
      chkb(cmp_a, 1'b1);
      chkb(cmp_b, 1'b0);
      setup(16'h0020, 16'h0030);
      mode(4'h9, 4'h0);
      ticks(1);
      clr_stat();
      ticks(32);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h02);
      ticks(32);
      chk_cnt(16'h0001);
      chk_reg(timer16_pkg::ADDR_STATUS, 8'h03);
   endtask
   task automatic t_capture();
      logic [3:0] m;
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         if (i != 13) begin
            mode(m, 4'h0);
            #1 chkb(cap_en, !(i == 8 || i == 10 || i == 12 || i == 14));
         end
      end
      for (int k = 0; k < 2; k++) begin
         mode(k == 0 ? 4'h0 : 4'hc, 4'h0);
         clr_stat();
         cap_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         cap_pin <= 1'b0;
         chk_reg(timer16_pkg::ADDR_STATUS, k == 0 ? 8'h20 : 8'h00);
      end
   endtask

   // ==========================================================
   // run control
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_regs();
      t_normal();
      t_fast();
      t_phase();
      t_top();
      t_capture();
      final_report();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      fail_count++;
      final_report();
   end
endmodule
